// [cbt_core.sv]
`timescale 1ns/100ps

module cbt_core (
	input  wire logic             REF_CLK,
	input  wire logic             NRST,
	input  wire logic             PSEL,
	input  wire logic             PENABLE,
	input  wire logic             PWRITE,
	input  wire logic [11:0]      PADDR,
	input  wire logic [31:0]      PWDATA,
	output logic      [31:0]      PRDATA,
	output logic                  PREADY,
	output logic                  PSLVERR,
	input  wire logic             SOFT_RESET,
	input  wire logic             RX_LINE,
	input  wire cbt_pkg::cbt_evt_t EVT,
	input  wire cbt_pkg::cbt_mbox_t MBOX,
	output logic                  SAMPLE_STROBE,
	output logic                  RX_BIT,
	output logic                  BIT_START,
	output logic                  IRQ
);
	import cbt_pkg::*;

	// ==========================================================
	// Helpers
	// Majority of three samples
	function automatic logic vote(input logic [2:0] s);
		vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : vote

	// Segment length in quanta is code plus one
	function automatic logic [4:0] seg_len(input logic [3:0] code);
		seg_len = {1'b0, code} + 5'h01;
	endfunction : seg_len

	// Smaller of a phase error and the jump width
	function automatic logic [4:0] clip(input logic [4:0] err, input logic [4:0] lim);
		clip = (err > lim) ? lim : err;
	endfunction : clip

	// ==========================================================
	// Bus decode
	logic        acc;
	logic        wr;
	logic        hit_timing;
	logic        hit_prescale;
	logic        hit_flags;
	logic        hit_mask;
	logic        hit_events;
	logic        hit_mbox;
	logic        hit_status;
	logic        hit_any;
	logic [15:0] wdata;

	// Full twelve-bit compare; aliases of a register would hide software
	// address errors behind a quiet bus
	assign acc          = PSEL & PENABLE;
	assign wr           = acc & PWRITE;
	assign wdata        = PWDATA[15:0];
	assign hit_timing   = PADDR == ADDR_TIMING;
	assign hit_prescale = PADDR == ADDR_PRESCALE;
	assign hit_flags    = PADDR == ADDR_IRQ_FLAGS;
	assign hit_mask     = PADDR == ADDR_IRQ_MASK;
	assign hit_events   = PADDR == ADDR_EVENTS;
	assign hit_mbox     = PADDR == ADDR_MBOX;
	assign hit_status   = PADDR == ADDR_STATUS;
	assign hit_any      = hit_timing | hit_prescale | hit_flags | hit_mask
	                    | hit_events | hit_mbox | hit_status;

	// ==========================================================
	// Software registers
	logic [15:0] timing_reg;
	logic [7:0]  prescale_reg;
	logic [15:0] irq_mask_reg;

	// Soft reset gives the same values as the pin reset, so software can
	// restart the timing without touching the reset line
	// Reserved bits never store, so they read back zero
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			timing_reg   <= TIMING_RESET;
			prescale_reg <= PRESCALE_RESET;
			irq_mask_reg <= MASK_RESET;
		end else if (SOFT_RESET) begin
			timing_reg   <= TIMING_RESET;
			prescale_reg <= PRESCALE_RESET;
			irq_mask_reg <= MASK_RESET;
		end else begin
			if (wr && hit_timing)
				timing_reg <= wdata & TIMING_RW;
			if (wr && hit_prescale)
				prescale_reg <= wdata[7:0];
			if (wr && hit_mask)
				irq_mask_reg <= wdata;
		end
	end

	logic [3:0] seg1_code;
	logic [2:0] seg2_code;
	logic [1:0] jump_code;
	logic       sample_mode_bit;
	logic [4:0] seg1_len;
	logic [4:0] seg2_len;
	logic [4:0] jump_width;

	// Field decode; prohibited codes are not trapped, they only give short
	// segments, so software must keep to the legal table
	assign seg1_code       = timing_reg[15:12];
	assign seg2_code       = timing_reg[10:8];
	assign jump_code       = timing_reg[5:4];
	assign sample_mode_bit = timing_reg[SAMPLE_MODE_POS];
	assign seg1_len        = seg_len(seg1_code);
	assign seg2_len        = seg_len({1'b0, seg2_code});
	assign jump_width      = seg_len({2'b00, jump_code});

	// ==========================================================
	// Quantum prescaler: 2*(field+1) clocks per quantum
	logic [8:0] presc_cnt;
	logic [8:0] presc_last;
	logic       tq_tick;

	// Greater-or-equal wraps at once when software shrinks the prescale
	// field below the running count, instead of counting round to 511
	assign presc_last = {prescale_reg, 1'b1};
	assign tq_tick    = presc_cnt >= presc_last;

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST)
			presc_cnt <= 9'h000;
		else if (SOFT_RESET || tq_tick)
			presc_cnt <= 9'h000;
		else
			presc_cnt <= presc_cnt + 9'h001;
	end

	// ==========================================================
	// Bit segment sequencer with resynchronisation
	// seg1_ext holds the phase correction of the running segment: quanta
	// added to segment one, or quanta cut from segment two; it is cleared at
	// each segment change, so one correction never leaks into the next
	logic       rx_prev;
	logic       edge_fall;
	cbt_seg_t   seg;
	cbt_seg_t   next_seg;
	logic [4:0] tq_cnt;
	logic [4:0] next_tq_cnt;
	logic [4:0] seg1_ext;
	logic [4:0] next_seg1_ext;
	logic [4:0] seg_end;
	logic [4:0] tq_left;
	logic [4:0] short_by;
	logic [4:0] late_by;
	logic       seg_done;
	logic       fix_free;
	logic       cut_now;

	assign edge_fall = rx_prev & ~RX_LINE;
	assign fix_free  = seg1_ext == 5'h00;
	assign seg_end   = (seg == SEG_ONE) ? seg1_len + seg1_ext : seg2_len - seg1_ext;
	// Greater-or-equal keeps a segment from running past its end when
	// software rewrites the timing register in mid-bit
	assign seg_done  = tq_tick && (tq_cnt >= seg_end - 5'h01);
	assign late_by   = clip(tq_cnt + 5'h01, jump_width);
	assign tq_left   = seg2_len - tq_cnt;
	assign short_by  = clip(tq_left, jump_width);
	// An early edge with no more than the jump width left ends the bit now
	assign cut_now   = edge_fall && fix_free && (tq_left <= jump_width);

	// Edge in sync slot needs no correction; late edge stretches phase one,
	// early edge (in segment two) cuts phase two by at most the jump width
	always_comb begin
		next_seg      = seg;
		next_tq_cnt   = tq_cnt;
		next_seg1_ext = seg1_ext;
		case (seg)
			SEG_SYNC: begin
				if (tq_tick) begin
					next_seg    = SEG_ONE;
					next_tq_cnt = 5'h00;
				end
			end
			SEG_ONE: begin
				if (edge_fall && fix_free)
					next_seg1_ext = late_by;
				if (seg_done) begin
					next_seg      = SEG_TWO;
					next_tq_cnt   = 5'h00;
					next_seg1_ext = 5'h00;
				end else if (tq_tick) begin
					next_tq_cnt = tq_cnt + 5'h01;
				end
			end
			SEG_TWO: begin
				if (edge_fall && fix_free)
					next_seg1_ext = short_by;
				if (seg_done || cut_now) begin
					next_seg      = SEG_SYNC;
					next_tq_cnt   = 5'h00;
					next_seg1_ext = 5'h00;
				end else if (tq_tick) begin
					next_tq_cnt = tq_cnt + 5'h01;
				end
			end
			default: begin
				next_seg      = SEG_SYNC;
				next_tq_cnt   = 5'h00;
				next_seg1_ext = 5'h00;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			seg      <= SEG_SYNC;
			tq_cnt   <= 5'h00;
			seg1_ext <= 5'h00;
			rx_prev  <= 1'b1;
		end else if (SOFT_RESET) begin
			seg      <= SEG_SYNC;
			tq_cnt   <= 5'h00;
			seg1_ext <= 5'h00;
			rx_prev  <= 1'b1;
		end else begin
			seg      <= next_seg;
			tq_cnt   <= next_tq_cnt;
			seg1_ext <= next_seg1_ext;
			rx_prev  <= RX_LINE;
		end
	end

	// ==========================================================
	// Sampling: one point, or three on the last clocks of segment one
	// The shift register runs through all of segment one, so at the sample
	// point it holds the two clocks before it, even with a two-clock quantum when segment one is at least two quanta long
	logic       in_win;
	logic [2:0] samples;
	logic       take;
	logic       bit_val;

	assign in_win   = seg == SEG_ONE;
	assign take     = seg_done && (seg == SEG_ONE);
	assign bit_val  = sample_mode_bit ? vote({samples[1:0], RX_LINE}) : RX_LINE;

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST)
			samples <= 3'h7;
		else if (in_win)
			samples <= {samples[1:0], RX_LINE};
	end

	// Pulses are registered, so each lands one clock after its cause
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			SAMPLE_STROBE <= 1'b0;
			RX_BIT        <= 1'b1;
			BIT_START     <= 1'b0;
		end else begin
			SAMPLE_STROBE <= take;
			BIT_START     <= (seg == SEG_SYNC) && tq_tick;
			if (take)
				RX_BIT <= bit_val;
		end
	end

	// ==========================================================
	// Interrupt flags
	logic [15:0] flags;
	logic [15:0] next_flags;
	logic [15:0] w1c;
	logic [15:0] irq_flags_reg;
	logic        overrun_hit;
	logic        overrun_idle;
	logic        mbox_empty;
	logic        rx_data_any;
	logic        rx_remote_any;

	assign w1c          = (wr && hit_flags) ? (wdata & FLAGS_W1C) : 16'h0000;
	assign overrun_hit  = EVT.rx_to_pending;
	assign overrun_idle = ~|(MBOX.unread_msg_status & ~MBOX.mbox_irq_mask);
	assign mbox_empty   = |((MBOX.tx_ack_bits | MBOX.abort_ack_bits)
	                      & ~MBOX.mbox_irq_mask);
	assign rx_data_any  = |(MBOX.rx_data_pending & ~MBOX.mbox_irq_mask);
	assign rx_remote_any = |(MBOX.rx_remote_pending & ~MBOX.mbox_irq_mask);

	// Set beats write-one-clear in the same cycle, so an event is never
	// lost to a clear that software issued a little too late
	always_comb begin
		next_flags = flags & ~w1c;
		if (EVT.test_mode && EVT.msg_error && !EVT.msg_overload)
			next_flags[FLAG_MSG_ERR] = 1'b1;
		if (EVT.asleep && !RX_LINE)
			next_flags[FLAG_SLEEP_ACT] = 1'b1;
		if (EVT.overload_cond)
			next_flags[FLAG_OVERLOAD] = 1'b1;
		if (EVT.tx_err_count >= BUSOFF_LEVEL || EVT.recovery_done || EVT.busoff_to_halt)
			next_flags[FLAG_BUSOFF] = 1'b1;
		if (EVT.mode_change)
			next_flags[FLAG_MODE_CHG] = 1'b1;
		if (overrun_hit)
			next_flags[FLAG_OVERRUN] = 1'b1;
		else if (overrun_idle)
			next_flags[FLAG_OVERRUN] = 1'b0;
		next_flags[FLAG_MBOX_EMPTY] = mbox_empty;
		next_flags[FLAG_RX_REMOTE]  = rx_remote_any;
		next_flags[FLAG_RX_DATA]    = rx_data_any;
		next_flags = next_flags & FLAGS_LIVE;
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST)
			flags <= FLAGS_RESET;
		else if (SOFT_RESET)
			flags <= FLAGS_RESET;
		else
			flags <= next_flags;
	end

	// Read view of the flags; bits 5 to 3 are not modelled and stay zero
	assign irq_flags_reg = flags;

	// ==========================================================
	// Bus answer: always ready, registered read data
	// Read data is taken in the setup cycle, so it stands through the single
	// access cycle in which ready is high
	logic [31:0] rd_mux;

	assign rd_mux = hit_timing   ? {16'h0000, timing_reg}
	              : hit_prescale ? {24'h000000, prescale_reg}
	              : hit_flags    ? {16'h0000, irq_flags_reg}
	              : hit_mask     ? {16'h0000, irq_mask_reg}
	              : hit_mbox     ? {16'h0000, MBOX.tx_ack_bits
	                                | MBOX.abort_ack_bits}
	              : hit_status   ? {25'h0000000, EVT.tx_err_count >= BUSOFF_LEVEL,
	                                4'h0, seg}
	              : 32'h00000000;

	// IRQ follows the next flag value, so it rises on the same edge as the flag
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			PRDATA  <= 32'h00000000;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			IRQ     <= 1'b0;
		end else begin
			PREADY  <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~hit_any;
			PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rd_mux : 32'h00000000;
			IRQ     <= |(next_flags & ~irq_mask_reg);
		end
	end

endmodule : cbt_core

// [cbt_pkg.sv]
package cbt_pkg;

	// ==========================================================
	// Register map (byte addresses; printed offsets not all x4)
	localparam logic [7:0]  IDX_TIMING    = 8'h04;
	localparam logic [7:0]  IDX_PRESCALE  = 8'h06;
	localparam logic [7:0]  IDX_IRQ_FLAGS = 8'h08;
	localparam logic [7:0]  IDX_IRQ_MASK  = 8'h0a;
	localparam logic [7:0]  IDX_EVENTS    = 8'h10;
	localparam logic [7:0]  IDX_MBOX      = 8'h12;
	localparam logic [7:0]  IDX_STATUS    = 8'h14;
	localparam logic [11:0] ADDR_TIMING    = {2'b00, IDX_TIMING, 2'b00};
	localparam logic [11:0] ADDR_PRESCALE  = {2'b00, IDX_PRESCALE, 2'b00};
	localparam logic [11:0] ADDR_IRQ_FLAGS = {2'b00, IDX_IRQ_FLAGS, 2'b00};
	localparam logic [11:0] ADDR_IRQ_MASK  = {2'b00, IDX_IRQ_MASK, 2'b00};
	localparam logic [11:0] ADDR_EVENTS    = {2'b00, IDX_EVENTS, 2'b00};
	localparam logic [11:0] ADDR_MBOX      = {2'b00, IDX_MBOX, 2'b00};
	localparam logic [11:0] ADDR_STATUS    = {2'b00, IDX_STATUS, 2'b00};

	// ==========================================================
	// Field positions and reset values
	localparam int          SAMPLE_MODE_POS = 0;
	localparam int          FLAG_MODE_CHG   = 0;
	localparam int          FLAG_RX_DATA    = 1;
	localparam int          FLAG_RX_REMOTE  = 2;
	localparam int          FLAG_BUSOFF     = 6;
	localparam int          FLAG_OVERLOAD   = 7;
	localparam int          FLAG_MBOX_EMPTY = 8;
	localparam int          FLAG_OVERRUN    = 9;
	localparam int          FLAG_SLEEP_ACT  = 12;
	localparam int          FLAG_MSG_ERR    = 13;
	localparam logic [15:0] FLAGS_RESET     = 16'h0001;
	localparam logic [15:0] FLAGS_W1C       = 16'h30c1;
	localparam logic [15:0] FLAGS_LIVE      = 16'h33c7;
	localparam logic [15:0] MASK_RESET      = 16'hffff;
	localparam logic [15:0] TIMING_RESET    = 16'h0000;
	localparam logic [15:0] TIMING_RW       = 16'hf731;
	localparam logic [7:0]  PRESCALE_RESET  = 8'h00;
	localparam logic [8:0]  BUSOFF_LEVEL    = 9'h100;
	localparam int          MBOX_N          = 16;
	localparam logic [2:0]  TRIPLE_WIN      = 3'h3;

	// ==========================================================
	// Bit timing state
	typedef enum logic [1:0] {
		SEG_SYNC = 2'b00,
		SEG_ONE  = 2'b01,
		SEG_TWO  = 2'b10
	} cbt_seg_t;

	// Mailbox status carried in from the mailbox store
	typedef struct packed {
		logic [MBOX_N-1:0] rx_data_pending;
		logic [MBOX_N-1:0] rx_remote_pending;
		logic [MBOX_N-1:0] unread_msg_status;
		logic [MBOX_N-1:0] tx_ack_bits;
		logic [MBOX_N-1:0] abort_ack_bits;
		logic [MBOX_N-1:0] mbox_irq_mask;
	} cbt_mbox_t;

	// One-cycle protocol events and the test mode, sleep and error count levels from the frame engine
	typedef struct packed {
		logic       test_mode;
		logic       msg_error;
		logic       msg_overload;
		logic       asleep;
		logic       overload_cond;
		logic       recovery_done;
		logic       busoff_to_halt;
		logic       mode_change;
		logic       rx_to_pending;
		logic [8:0] tx_err_count;
	} cbt_evt_t;

endpackage : cbt_pkg

// [cbt_core_assertions.sv]
`timescale 1ns/100ps

// ==========================================================
// Port level checks for the bit timing and flag core
module cbt_core_assertions
	import cbt_pkg::*;
(
	input wire logic        REF_CLK,
	input wire logic        NRST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        SAMPLE_STROBE,
	input wire logic        RX_BIT,
	input wire logic        BIT_START,
	input wire logic        IRQ
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	// Zero wait states, so the answer must be in the first access cycle
	a_ready_access: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |-> PREADY)
		else $error("no ready in first access cycle");
	a_pready_one: assert property (PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");
	a_slverr_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_unmapped_err: assert property (PSEL && !PENABLE && PADDR == 12'h0fc |=> PSLVERR)
		else $error("unmapped address not refused");
	a_prescale_rsvd: assert property (PREADY && !PWRITE && PADDR == ADDR_PRESCALE
		|-> PRDATA[31:8] == 24'h0)
		else $error("prescale upper bits not zero");
	a_flags_rsvd: assert property (PREADY && !PWRITE && PADDR == ADDR_IRQ_FLAGS
		|-> PRDATA[31:14] == 18'h0 && PRDATA[11:10] == 2'h0)
		else $error("reserved flag bits not zero");
	// Mask is registered, so the output may lag the write by one more edge
	a_mask_quiets: assert property (PREADY && PWRITE && PADDR == ADDR_IRQ_MASK
		&& PWDATA[15:0] == 16'hffff |-> ##2 !IRQ)
		else $error("interrupt not quiet with all masked");
	a_pulse_apart: assert property (BIT_START |-> !SAMPLE_STROBE ##1 !SAMPLE_STROBE
		&& !BIT_START)
		else $error("sample too close to bit start");
	a_strobe_one: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE)
		else $error("sample strobe longer than one cycle");

	c_refused: cover property (PSLVERR);
	c_dominant: cover property (SAMPLE_STROBE && !RX_BIT);
	c_irq: cover property ($rose(IRQ));
endmodule : cbt_core_assertions

bind cbt_core cbt_core_assertions cbt_core_assertions_inst (.REF_CLK, .NRST, .PSEL,
	.PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SAMPLE_STROBE,
	.RX_BIT, .BIT_START, .IRQ);

// [cbt_bus_model.sv]
`timescale 1ns/100ps

// ==========================================================
// Bus side: other nodes drive the receive level bit by bit
module cbt_bus_model (
	input wire logic ref_clk,
	input wire logic bit_start,
	input wire logic tx_level,
	output logic     rx_line
);
	initial rx_line = 1'b1;
	// Level changes one clock after the bit start pulse, so a falling edge
	// lands early in segment one and stretches it by one quantum
	always @(posedge ref_clk) begin
		if (bit_start) rx_line <= tx_level;
	end
endmodule : cbt_bus_model

// [test_can_bit_timing_and_irq_flags.sv]
`timescale 1ns/100ps

// ==========================================================
// Self-checking bench
module test_can_bit_timing_and_irq_flags;
	import cbt_pkg::*;
	logic        ref_clk, nrst, psel, penable, pwrite, soft_reset, tx_level, rx_line;
	logic        pready, pslverr, sample_strobe, rx_bit, bit_start, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	cbt_evt_t    evt;
	cbt_mbox_t   mbox;
	int          n_errors, checks;
	int          cyc = 0;

	always #2.5 ref_clk = ~ref_clk;

	cbt_core cbt_core_inst (.REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SOFT_RESET(soft_reset), .RX_LINE(rx_line), .EVT(evt),
		.MBOX(mbox), .SAMPLE_STROBE(sample_strobe), .RX_BIT(rx_bit),
		.BIT_START(bit_start), .IRQ(irq));
	cbt_bus_model cbt_bus_model_inst (.ref_clk(ref_clk), .bit_start(bit_start),
		.tx_level(tx_level), .rx_line(rx_line));

	task complete_run;
		$display("n_errors=%0d checks=%0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	// Hang guard: the run needs about 17000 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			complete_run;
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk

	// One APB transfer; result left in r and e
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask : rd

	task fl(input int b, input logic x);
		apb(1'b0, ADDR_IRQ_FLAGS, 32'h0);
		chk({31'h0, r[b]}, {31'h0, x});
	endtask : fl

	task pulse(input cbt_evt_t p);
		@(posedge ref_clk);
		evt <= cbt_evt_t'(evt | p);
		@(posedge ref_clk);
		evt <= cbt_evt_t'(evt & ~p);
	endtask : pulse

	task bits(input int n);
		repeat (n) do @(posedge ref_clk); while (bit_start !== 1'b1);
	endtask : bits

	task t_regs;
		rd(ADDR_IRQ_FLAGS, 32'h1);
		rd(ADDR_IRQ_MASK, 32'hffff);
		rd(ADDR_TIMING, 32'h0);
		rd(ADDR_PRESCALE, 32'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_PRESCALE, 32'hffff);
		rd(ADDR_PRESCALE, 32'hff);
		apb(1'b1, ADDR_TIMING, 32'hffff);
		rd(ADDR_TIMING, 32'hf731);
		apb(1'b0, 12'h0fc, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		rd(ADDR_EVENTS, 32'h0);
	endtask : t_regs

	// Measures one bit period after the new setting has settled
	task t_bit(input logic [7:0] p, input logic [3:0] s1, input logic [2:0] s2,
		input logic [1:0] j, input logic sm);
		int n;
		n = 0;
		tx_level <= sm;
		apb(1'b1, ADDR_PRESCALE, {24'h0, p});
		apb(1'b1, ADDR_TIMING, {16'h0, s1, 1'b0, s2, 2'b0, j, 3'b0, sm});
		bits(3);
		do begin
			@(posedge ref_clk);
			n++;
		end while (bit_start !== 1'b1);
		chk(n, 2 * (p + 1) * (s1 + s2 + 3));
		chk({31'h0, rx_bit}, {31'h0, sm});
	endtask : t_bit

	task t_flags;
		cbt_evt_t p;
		p = '0;
		p.msg_error = 1'b1;
		pulse(p);
		fl(FLAG_MSG_ERR, 1'b0);
		evt.test_mode <= 1'b1;
		p = '0;
		p.msg_overload = 1'b1;
		pulse(p);
		fl(FLAG_MSG_ERR, 1'b0);
		p = '0;
		p.msg_error = 1'b1;
		pulse(p);
		fl(FLAG_MSG_ERR, 1'b1);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h2000);
		fl(FLAG_MSG_ERR, 1'b0);
		evt.test_mode <= 1'b0;
		apb(1'b1, ADDR_IRQ_MASK, 32'hff7f);
		p = '0;
		p.overload_cond = 1'b1;
		pulse(p);
		fl(FLAG_OVERLOAD, 1'b1);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, ADDR_IRQ_MASK, 32'hffff);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h0);
		fl(FLAG_OVERLOAD, 1'b1);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h80);
		fl(FLAG_OVERLOAD, 1'b0);
		evt.tx_err_count <= 9'h100;
		repeat (2) @(posedge ref_clk);
		evt.tx_err_count <= 9'h0;
		fl(FLAG_BUSOFF, 1'b1);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h0);
		fl(FLAG_BUSOFF, 1'b1);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h40);
		fl(FLAG_BUSOFF, 1'b0);
		p = '0;
		p.recovery_done = 1'b1;
		pulse(p);
		fl(FLAG_BUSOFF, 1'b1);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h40);
		p = '0;
		p.busoff_to_halt = 1'b1;
		pulse(p);
		fl(FLAG_BUSOFF, 1'b1);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h1);
		fl(FLAG_MODE_CHG, 1'b0);
		p = '0;
		p.mode_change = 1'b1;
		pulse(p);
		fl(FLAG_MODE_CHG, 1'b1);
	endtask : t_flags

	task t_sleep;
		tx_level <= 1'b0;
		bits(3);
		fl(FLAG_SLEEP_ACT, 1'b0);
		evt.asleep <= 1'b1;
		bits(2);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h0);
		fl(FLAG_SLEEP_ACT, 1'b1);
		evt.asleep <= 1'b0;
		tx_level <= 1'b1;
		bits(2);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h1000);
		fl(FLAG_SLEEP_ACT, 1'b0);
	endtask : t_sleep

	task t_mbox;
		cbt_evt_t p;
		mbox.tx_ack_bits <= 16'h0008;
		fl(FLAG_MBOX_EMPTY, 1'b1);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h0100);
		fl(FLAG_MBOX_EMPTY, 1'b1);
		mbox.mbox_irq_mask <= 16'h0008;
		fl(FLAG_MBOX_EMPTY, 1'b0);
		mbox.abort_ack_bits <= 16'h0020;
		fl(FLAG_MBOX_EMPTY, 1'b1);
		rd(ADDR_MBOX, 32'h28);
		mbox.unread_msg_status <= 16'h0004;
		p = '0;
		p.rx_to_pending = 1'b1;
		pulse(p);
		fl(FLAG_OVERRUN, 1'b1);
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h0200);
		fl(FLAG_OVERRUN, 1'b1);
		mbox.mbox_irq_mask <= 16'h000c;
		fl(FLAG_OVERRUN, 1'b0);
		mbox.rx_data_pending <= 16'h0001;
		fl(FLAG_RX_DATA, 1'b1);
		mbox.rx_remote_pending <= 16'h0002;
		apb(1'b1, ADDR_IRQ_FLAGS, 32'h0006);
		fl(FLAG_RX_REMOTE, 1'b1);
		mbox.mbox_irq_mask <= 16'h000f;
		fl(FLAG_RX_DATA, 1'b0);
		// Soft reset must bring every flag back to its reset value
		@(posedge ref_clk);
		mbox <= '0;
		soft_reset <= 1'b1;
		@(posedge ref_clk);
		soft_reset <= 1'b0;
		rd(ADDR_IRQ_FLAGS, 32'h1);
	endtask : t_mbox

	// With 4-clock quanta and 5+2+1 quanta per bit, a falling edge just
	// after the sync slot adds one quantum to that bit only
	task t_resync;
		int n;
		n = 0;
		bits(1);
		tx_level <= 1'b0;
		bits(1);
		do begin
			@(posedge ref_clk);
			n++;
		end while (bit_start !== 1'b1);
		chk(n, 32'd36);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (bit_start !== 1'b1);
		chk(n, 32'd32);
	endtask : t_resync

	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		soft_reset = 1'b0;
		tx_level = 1'b1;
		evt = '0;
		mbox = '0;
		n_errors = 0;
		checks = 0;
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		t_regs;
		t_bit(8'hff, 4'h4, 3'h1, 2'h0, 1'b0);
		t_bit(8'h00, 4'hf, 3'h7, 2'h3, 1'b1);
		t_bit(8'h01, 4'h4, 3'h1, 2'h1, 1'b0);
		t_flags;
		t_sleep;
		t_resync;
		t_mbox;
		complete_run;
	end
endmodule : test_can_bit_timing_and_irq_flags
